// *** mio_pkg.sv ***
// Constants and types shared by the configuration block and its pin synchroniser
package mio_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned XTAL_STAB_NS  = 8_000_000;
  // Longest wait rounds down to whole cycles
  localparam int unsigned XTAL_STAB_CYC = XTAL_STAB_NS / CLK_PERIOD_NS;
  localparam int unsigned STAB_W        = 19;
  localparam logic [2:0]  INIT_CYC      = 3'h5;

  // Configuration index values
  localparam logic [7:0] IDX_FER = 8'h00;
  localparam logic [7:0] IDX_FAR = 8'h01;
  localparam logic [7:0] IDX_PTR = 8'h02;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Index/data pair locations per base strap
  localparam logic [9:0] CFG_IDX_ADDR0 = 10'h398;
  localparam logic [9:0] CFG_IDX_ADDR1 = 10'h26E;

  // Parallel port ranges
  localparam logic [1:0] LPT_SEL_378 = 2'h0;
  localparam logic [1:0] LPT_SEL_3BC = 2'h1;
  localparam logic [1:0] LPT_SEL_278 = 2'h2;
  localparam logic [1:0] LPT_SEL_RSV = 2'h3;
  localparam logic [9:0] LPT_BASE_378 = 10'h378;
  localparam logic [9:0] LPT_BASE_3BC = 10'h3BC;
  localparam logic [9:0] LPT_BASE_278 = 10'h278;

  // Serial port ranges
  localparam logic [9:0] COM1_BASE = 10'h3F8;
  localparam logic [9:0] COM2_BASE = 10'h2F8;
  localparam logic [9:0] COM3_BASE0 = 10'h3E8;
  localparam logic [9:0] COM3_BASE1 = 10'h338;
  localparam logic [9:0] COM3_BASE2 = 10'h2E8;
  localparam logic [9:0] COM3_BASE3 = 10'h220;
  localparam logic [9:0] COM4_BASE0 = 10'h2E8;
  localparam logic [9:0] COM4_BASE1 = 10'h238;
  localparam logic [9:0] COM4_BASE2 = 10'h2E0;
  localparam logic [9:0] COM4_BASE3 = 10'h228;

  // Function enable field positions
  localparam int unsigned FER_LPT   = 0;
  localparam int unsigned FER_UART1 = 1;
  localparam int unsigned FER_UART2 = 2;
  localparam int unsigned FER_FDC   = 3;

  // Reset values of the upper enable bits and the address register
  localparam logic [3:0] FER_HI_RST = 4'h0;
  localparam logic [7:0] FAR_RST    = 8'h00;

  // Function address select layout
  typedef struct packed {
    logic [1:0] com34_sel;
    logic [1:0] uart2_com;
    logic [1:0] uart1_com;
    logic [1:0] lpt_sel;
  } mio_far_t;

  // Power and test control layout
  typedef struct packed {
    logic mode_ext;
    logic lock;
    logic uart2_test;
    logic uart1_test;
    logic lpt_irq7;
    logic pin_cs;
    logic xtal_sel;
    logic soft_pd;
  } mio_ptr_t;

  localparam mio_ptr_t PTR_RST = '0;

  // Crystal control states
  typedef enum logic [2:0] {
    MIO_XS_RUN  = 3'h1,
    MIO_XS_STOP = 3'h2,
    MIO_XS_STAB = 3'h4
  } mio_xs_t;

endpackage

// *** mio_sync3.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mio_sync3 #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_out
);
  import mio_pkg::*;

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] nxt_lvl;

  // Take stage two only where it matches stage three, else hold
  assign nxt_lvl = ((s2_ff ^~ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & lvl_ff);

  // Stage one feeds stage two only, so metastability stays contained
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      lvl_ff <= RST_VAL;
    end
    else
    begin
      s1_ff  <= pin_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;
endmodule
`default_nettype wire

// *** mio_cfg_top.sv ***
// Configuration registers, address map and power control of the multi-function I/O device
// Contract
// - address bits 1:0 place parallel port; code 11 reserved, interrupt undriven.
// - AT mode gives IRQ5 for 378/278, IRQ7 for 3BC; XT always IRQ7.
// - power/test bit 3 moves 378 range interrupt to IRQ7 only.
// - address bits 3:2 pick first UART COM1 to COM4.
// - address bits 5:4 pick second UART COM number, same coding.
// - address bits 7:6 pick COM3/COM4 ranges; COM3 IRQ4, COM4 IRQ3.
// - power/test bit 0 powers down enabled functions; registers kept.
// - bit 1 chooses clocks-only stop or crystal stop on power-down.
// - crystal restart needs about 8 ms settling; clocks-only stop needs none.
// - power/test bit 2 turns shared pin into chip-select output.
// - UART test bits drive baud clock on serial out when LCR7 set.
// - lock bit blocks config writes; only hardware reset clears it.
// - bit 7 selects port mode; resets to inverse of mode strap.
// - single function clock stops on disable, strap, or FDC low power.
// - all enabled clocks stop on pin or soft power-down, crystal select 0.
// - clocks of disabled functions stay off always.
// - crystal stops on no enables, crystal-select power-down, or all straps high.
// - FDC request-for-master held clear until crystal settles.
// - UART clock resumes with enable set, no soft or pin power-down; code also needs no FDC low power with crystal select.
// - FDC clock resumes with enable set, no soft or pin power-down, no FDC low power.
// - enable bits 1..3 gate access and power of UARTs and FDC.
// - base strap places index/data pair at 398h or 26Eh.
`timescale 1ns/1ps
`default_nettype none
module mio_cfg_top #(
  parameter int unsigned STAB_CYC = mio_pkg::XTAL_STAB_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [9:0] isa_addr,
  input  wire logic       isa_aen,
  input  wire logic       isa_ior_n,
  input  wire logic       isa_iow_n,
  input  wire logic [7:0] isa_data_in,
  output var  logic [7:0] isa_data_out,
  output var  logic       isa_data_oe_n,
  input  wire logic       config_base_strap,
  input  wire logic       port_mode_strap_pin,
  input  wire logic [4:0] config_strap_pins,
  input  wire logic       xt_mode_pin,
  input  wire logic       power_down_pin_n,
  output var  logic       chip_select_out_pin_n,
  output var  logic       chip_select_oe_n,
  input  wire logic       uart1_sout_raw,
  input  wire logic       uart1_baudout,
  input  wire logic       uart1_lcr7,
  input  wire logic       uart2_sout_raw,
  input  wire logic       uart2_baudout,
  input  wire logic       uart2_lcr7,
  input  wire logic       fdc_low_power_cmd,
  input  wire logic       fdc_rate_low_power,
  output var  logic       serial_out_first,
  output var  logic       serial_out_second,
  output var  logic [7:0] function_enable_reg,
  output var  logic [9:0] lpt_base,
  output var  logic       lpt_irq7_sel,
  output var  logic       lpt_irq_oe_n,
  output var  logic       port_extended_mode,
  output var  logic [9:0] uart1_base,
  output var  logic       uart1_irq4_sel,
  output var  logic [9:0] uart2_base,
  output var  logic       uart2_irq4_sel,
  output var  logic       uart1_clk_en,
  output var  logic       uart2_clk_en,
  output var  logic       fdc_clk_en,
  output var  logic       xtal_stop,
  output var  logic       fdc_rqm_hold
);
  import mio_pkg::*;

  // Base address of a serial port from its COM number and the COM3/4 choice
  function automatic logic [9:0] com_base(input logic [1:0] com, input logic [1:0] sel);
    logic [9:0] b;
    b = COM1_BASE;
    case (com)
      2'h0: b = COM1_BASE;
      2'h1: b = COM2_BASE;
      2'h2: b = (sel == 2'h0) ? COM3_BASE0 : (sel == 2'h1) ? COM3_BASE1 :
                (sel == 2'h2) ? COM3_BASE2 : COM3_BASE3;
      default: b = (sel == 2'h0) ? COM4_BASE0 : (sel == 2'h1) ? COM4_BASE1 :
                   (sel == 2'h2) ? COM4_BASE2 : COM4_BASE3;
    endcase
    return b;
  endfunction

  // COM1 and COM3 share IRQ4, COM2 and COM4 share IRQ3
  function automatic logic com_irq4(input logic [1:0] com);
    return ~com[0];
  endfunction

  // Reset release through two flops
  logic rs1_ff;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_ff     <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rs1_ff     <= 1'b1;
      rst_sync_n <= rs1_ff;
    end
  end

  // Pin synchronisers: strobes and power-down idle high, straps idle low
  logic [2:0] ctl_lvl;
  logic [6:0] strap_lvl;
  mio_sync3 #(.W(3), .RST_VAL(3'h7)) u_ctl_sync (
    .mclk      (mclk),
    .rst_n     (rst_sync_n),
    .pin_in    ({power_down_pin_n, isa_iow_n, isa_ior_n}),
    .level_out (ctl_lvl)
  );
  mio_sync3 #(.W(7), .RST_VAL(7'h00)) u_strap_sync (
    .mclk      (mclk),
    .rst_n     (rst_sync_n),
    .pin_in    ({port_mode_strap_pin, config_base_strap, config_strap_pins}),
    .level_out (strap_lvl)
  );

  wire ior_l = ctl_lvl[0];
  wire iow_l = ctl_lvl[1];
  wire power_down_pin_l = ctl_lvl[2];

  // Straps are captured once the synchroniser has settled after release
  logic [2:0] init_cnt_ff;
  wire init_done = (init_cnt_ff == INIT_CYC);
  wire capture = (init_cnt_ff == INIT_CYC - 3'h1);

  logic [7:0]  fer_ff;
  mio_far_t    far_ff;
  mio_ptr_t    ptr_ff;
  logic [7:0]  index_ff;
  logic        base_sel_ff;
  logic        ior_q_ff;
  logic        iow_q_ff;

  // Index/data decode for the strap-chosen location
  wire [9:0] idx_addr = base_sel_ff ? CFG_IDX_ADDR1 : CFG_IDX_ADDR0;
  wire       hit_idx = !isa_aen && (isa_addr == idx_addr);
  wire       hit_dat = !isa_aen && (isa_addr == idx_addr + 10'h001);
  wire       rd_go = init_done && ior_q_ff && !ior_l;
  wire       wr_go = init_done && iow_q_ff && !iow_l;
  wire       wr_dat = wr_go && hit_dat && !ptr_ff.lock;

  // Selected register for data reads; unknown indexes read a fixed value
  wire [7:0] rd_reg = (index_ff == IDX_FER) ? fer_ff :
                      (index_ff == IDX_FAR) ? far_ff :
                      (index_ff == IDX_PTR) ? ptr_ff : UNMAPPED_RD;
  wire [7:0] rd_val = hit_idx ? index_ff : rd_reg;

  // The lock bit is sticky: a write may set it, never clear it
  mio_ptr_t nxt_ptr;
  always_comb
  begin
    nxt_ptr = isa_data_in;
    nxt_ptr.lock = isa_data_in[6] | ptr_ff.lock;
  end

  // Initialisation, strobe history and index register
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      init_cnt_ff <= 3'h0;
      ior_q_ff    <= 1'b1;
      iow_q_ff    <= 1'b1;
      index_ff    <= IDX_FER;
    end
    else
    begin
      init_cnt_ff <= init_done ? init_cnt_ff : init_cnt_ff + 3'h1;
      ior_q_ff    <= ior_l;
      iow_q_ff    <= iow_l;
      if (wr_go && hit_idx)
        index_ff <= isa_data_in;
    end
  end

  // Configuration registers; straps set power-up enables and port mode
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fer_ff      <= '0;
      far_ff      <= FAR_RST;
      ptr_ff      <= PTR_RST;
      base_sel_ff <= 1'b0;
    end
    else if (capture)
    begin
      fer_ff      <= {FER_HI_RST, ~strap_lvl[3:0]};
      ptr_ff.mode_ext <= ~strap_lvl[6];
      base_sel_ff <= strap_lvl[5];
    end
    else if (wr_dat)
    begin
      if (index_ff == IDX_FER)
        fer_ff <= isa_data_in;
      if (index_ff == IDX_FAR)
        far_ff <= isa_data_in;
      if (index_ff == IDX_PTR)
        ptr_ff <= nxt_ptr;
    end
  end

  // Read data is captured at strobe start and driven until it ends
  logic [7:0] dout_ff;
  logic       doe_n_ff;
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dout_ff  <= 8'h00;
      doe_n_ff <= 1'b1;
    end
    else if (rd_go && (hit_idx || hit_dat))
    begin
      dout_ff  <= rd_val;
      doe_n_ff <= 1'b0;
    end
    else if (ior_l)
      doe_n_ff <= 1'b1;
  end

  // Power-down sources; the pin only counts in power-down function
  wire pin_pd  = !ptr_ff.pin_cs && !power_down_pin_l;
  wire pd_all  = ptr_ff.soft_pd || pin_pd;
  wire fdc_lp  = fdc_low_power_cmd || fdc_rate_low_power;
  wire no_en   = (fer_ff[FER_FDC:FER_UART1] == 3'h0);
  // Crystal stops on no enables, or on power-down or FDC low power with crystal select; straps all high clear every enable
  wire xtal_req = init_done && (no_en || (ptr_ff.xtal_sel && (pd_all || fdc_lp)));

  // Each clock needs its enable and no power-down; disabled stays off
  wire u1_on = fer_ff[FER_UART1] && !pd_all && !xtal_req;
  wire u2_on = fer_ff[FER_UART2] && !pd_all && !xtal_req;
  wire fd_on = fer_ff[FER_FDC] && !pd_all && !xtal_req && !fdc_lp;

  // Crystal state: settling only follows a crystal stop, not a clock stop
  mio_xs_t            xs_ff;
  mio_xs_t            nxt_xs;
  logic [STAB_W-1:0]  stab_cnt_ff;
  logic [STAB_W-1:0]  nxt_stab;
  localparam logic [STAB_W-1:0] STAB_LOAD = STAB_W'(STAB_CYC - 1);

  always_comb
  begin
    nxt_xs = xs_ff;
    nxt_stab = stab_cnt_ff;
    case (xs_ff)
      MIO_XS_RUN:
        if (xtal_req)
          nxt_xs = MIO_XS_STOP;
      MIO_XS_STOP:
        if (!xtal_req)
        begin
          nxt_xs = MIO_XS_STAB;
          nxt_stab = STAB_LOAD;
        end
      MIO_XS_STAB:
        if (xtal_req)
          nxt_xs = MIO_XS_STOP;
        else if (stab_cnt_ff == '0)
          nxt_xs = MIO_XS_RUN;
        else
          nxt_stab = stab_cnt_ff - 1'b1;
      default:
        nxt_xs = MIO_XS_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      xs_ff       <= MIO_XS_RUN;
      stab_cnt_ff <= '0;
    end
    else
    begin
      xs_ff       <= nxt_xs;
      stab_cnt_ff <= nxt_stab;
    end
  end

  // Address map and interrupt routing
  wire [1:0] lsel = far_ff.lpt_sel;
  wire [9:0] lpt_b = (lsel == LPT_SEL_3BC) ? LPT_BASE_3BC :
                     (lsel == LPT_SEL_278) ? LPT_BASE_278 : LPT_BASE_378;
  wire lpt_i7 = xt_mode_pin || (lsel == LPT_SEL_3BC) ||
                ((lsel == LPT_SEL_378) && ptr_ff.lpt_irq7);
  // Chip select follows any strobe aimed at the configuration pair
  wire cs_act = ptr_ff.pin_cs && (!ior_l || !iow_l) && (hit_idx || hit_dat);

  // Registered outputs; clock changes take effect one cycle later
  logic [7:0] fer_o_ff;
  logic [9:0] lpt_b_ff;
  logic [9:0] u1_b_ff;
  logic [9:0] u2_b_ff;
  logic       lpt_i7_ff;
  logic       lpt_oe_n_ff;
  logic       u1_i4_ff;
  logic       u2_i4_ff;
  logic       so1_ff;
  logic       so2_ff;
  logic       u1_clk_ff;
  logic       u2_clk_ff;
  logic       fd_clk_ff;
  logic       xstop_ff;
  logic       rqm_ff;
  logic       cs_n_ff;
  logic       cs_oe_n_ff;
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fer_o_ff    <= '0;
      lpt_b_ff    <= LPT_BASE_378;
      u1_b_ff     <= COM1_BASE;
      u2_b_ff     <= COM1_BASE;
      lpt_i7_ff   <= 1'b0;
      lpt_oe_n_ff <= 1'b1;
      u1_i4_ff    <= 1'b1;
      u2_i4_ff    <= 1'b1;
      so1_ff      <= 1'b1;
      so2_ff      <= 1'b1;
      u1_clk_ff   <= 1'b0;
      u2_clk_ff   <= 1'b0;
      fd_clk_ff   <= 1'b0;
      xstop_ff    <= 1'b0;
      rqm_ff      <= 1'b1;
      cs_n_ff     <= 1'b1;
      cs_oe_n_ff  <= 1'b1;
    end
    else
    begin
      fer_o_ff    <= fer_ff;
      lpt_b_ff    <= lpt_b;
      u1_b_ff     <= com_base(far_ff.uart1_com, far_ff.com34_sel);
      u2_b_ff     <= com_base(far_ff.uart2_com, far_ff.com34_sel);
      lpt_i7_ff   <= lpt_i7;
      lpt_oe_n_ff <= (lsel == LPT_SEL_RSV) || !fer_ff[FER_LPT];
      u1_i4_ff    <= com_irq4(far_ff.uart1_com);
      u2_i4_ff    <= com_irq4(far_ff.uart2_com);
      so1_ff      <= (ptr_ff.uart1_test && uart1_lcr7) ? uart1_baudout : uart1_sout_raw;
      so2_ff      <= (ptr_ff.uart2_test && uart2_lcr7) ? uart2_baudout : uart2_sout_raw;
      u1_clk_ff   <= u1_on;
      u2_clk_ff   <= u2_on;
      fd_clk_ff   <= fd_on;
      xstop_ff    <= (nxt_xs == MIO_XS_STOP);
      rqm_ff      <= (nxt_xs != MIO_XS_RUN);
      cs_n_ff     <= !cs_act;
      cs_oe_n_ff  <= !ptr_ff.pin_cs;
    end
  end

  assign isa_data_out          = dout_ff;
  assign isa_data_oe_n         = doe_n_ff;
  assign function_enable_reg   = fer_o_ff;
  assign lpt_base              = lpt_b_ff;
  assign lpt_irq7_sel          = lpt_i7_ff;
  assign lpt_irq_oe_n          = lpt_oe_n_ff;
  assign port_extended_mode    = ptr_ff.mode_ext;
  assign uart1_base            = u1_b_ff;
  assign uart2_base            = u2_b_ff;
  assign uart1_irq4_sel        = u1_i4_ff;
  assign uart2_irq4_sel        = u2_i4_ff;
  assign serial_out_first      = so1_ff;
  assign serial_out_second     = so2_ff;
  assign uart1_clk_en          = u1_clk_ff;
  assign uart2_clk_en          = u2_clk_ff;
  assign fdc_clk_en            = fd_clk_ff;
  assign xtal_stop             = xstop_ff;
  assign fdc_rqm_hold          = rqm_ff;
  assign chip_select_out_pin_n = cs_n_ff;
  assign chip_select_oe_n      = cs_oe_n_ff;

  // Checks next to the logic they guard
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_lock_blocks_wr: assert property (
    (ptr_ff.lock && wr_go && hit_dat) |=> ($stable(fer_ff) && $stable(far_ff) && $stable(ptr_ff))
  ) else $error("config write passed while locked");

  a_lpt_rsv_float: assert property (
    (lsel == LPT_SEL_RSV) |=> lpt_irq_oe_n
  ) else $error("reserved port range drives interrupt");

  a_lpt_at_irq5: assert property (
    (!xt_mode_pin && (lsel == LPT_SEL_278)) |=> !lpt_irq7_sel
  ) else $error("278 range in AT mode not on IRQ5");

  a_lpt_move_irq7: assert property (
    ((lsel == LPT_SEL_378) && ptr_ff.lpt_irq7) |=> lpt_irq7_sel
  ) else $error("378 range not moved to IRQ7");

  a_uart_test_out: assert property (
    (ptr_ff.uart1_test && uart1_lcr7) |=> (serial_out_first == $past(uart1_baudout))
  ) else $error("test mode does not show baud clock");

  a_xtal_stop_sel: assert property (
    (init_done && ptr_ff.soft_pd && ptr_ff.xtal_sel) |=> ##[0:1] xtal_stop
  ) else $error("crystal not stopped on crystal power-down");

  a_clk_only_pd: assert property (
    (ptr_ff.soft_pd && !ptr_ff.xtal_sel) |=> (!uart1_clk_en && !uart2_clk_en && !fdc_clk_en)
  ) else $error("clocks run during soft power-down");

  a_disabled_off: assert property (
    !fer_ff[FER_UART1] |=> !uart1_clk_en
  ) else $error("disabled UART clock active");

  a_uart_resume: assert property (
    (fer_ff[FER_UART1] && !pd_all && !xtal_req) |=> uart1_clk_en
  ) else $error("UART clock did not resume");

  a_rqm_settle: assert property (
    ((xs_ff == MIO_XS_STAB) && (stab_cnt_ff != '0)) |=> fdc_rqm_hold
  ) else $error("request bit released before settling");
endmodule
`default_nettype wire

// *** mio_host_bfm.sv ***
// Host model that runs ISA I/O cycles against the configuration block
`timescale 1ns/1ps
`default_nettype none
module mio_host_bfm (
  input  wire logic       mclk,
  output var  logic [9:0] isa_addr,
  output var  logic       isa_aen,
  output var  logic       isa_ior_n,
  output var  logic       isa_iow_n,
  output var  logic [7:0] isa_data_in,
  input  wire logic [7:0] isa_data_out
);
  // Idle bus: not addressed, so no decode can hit by accident
  initial
  begin
    isa_addr    = 10'h3FF;
    isa_aen     = 1'b1;
    isa_ior_n   = 1'b1;
    isa_iow_n   = 1'b1;
    isa_data_in = 8'hFF;
  end

  // One strobe held 7 cycles low and 4 high so the 3-flop filter sees both levels
  task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic rd,
                     output logic [7:0] q);
    @(posedge mclk);
    isa_addr    <= a;
    isa_aen     <= 1'b0;
    isa_data_in <= d;
    isa_ior_n   <= !rd;
    isa_iow_n   <= rd;
    repeat (7) @(posedge mclk);
    q = isa_data_out;
    isa_ior_n   <= 1'b1;
    isa_iow_n   <= 1'b1;
    isa_aen     <= 1'b1;
    // Released lines show the inverse so a stale value never matches
    isa_addr    <= ~a;
    isa_data_in <= ~d;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** multi_io_address_power_config_tb.sv ***
// Self-checking bench for the address map, power control and lock of the configuration block
`timescale 1ns/1ps
`default_nettype none
module multi_io_address_power_config_tb;
  import mio_pkg::*;
  typedef struct packed {
    logic [7:0] function_address_select, ptr;
    logic       xt;
    logic [9:0] lb;
    logic       l7, loe;
    logic [9:0] b1;
    logic       i1;
    logic [9:0] b2;
    logic       i2;
  } mio_row_t;
  localparam int unsigned STAB = 20;
  logic       mclk, rst_n, isa_aen, isa_ior_n, isa_iow_n, isa_data_oe_n;
  logic       config_base_strap, port_mode_strap_pin, xt_mode_pin, power_down_pin_n;
  logic       chip_select_out_pin_n, chip_select_oe_n, serial_out_first, serial_out_second;
  logic       uart1_sout_raw, uart1_baudout, uart1_lcr7, uart2_sout_raw, uart2_baudout;
  logic       uart2_lcr7, fdc_low_power_cmd, fdc_rate_low_power, lpt_irq7_sel, lpt_irq_oe_n;
  logic       port_extended_mode, uart1_irq4_sel, uart2_irq4_sel, uart1_clk_en;
  logic       uart2_clk_en, fdc_clk_en, xtal_stop, fdc_rqm_hold;
  logic [4:0] config_strap_pins;
  logic [7:0] isa_data_in, isa_data_out, function_enable_reg;
  logic [9:0] isa_addr, lpt_base, uart1_base, uart2_base, cfg_base;
  int         n_errors, comparisons;
  logic [7:0] q;
  // Address, interrupt and interrupt-enable expectations, one row per case
  mio_row_t rows [8] = '{
    '{8'h00, 8'h00, 1'b0, 10'h378, 1'b0, 1'b0, 10'h3F8, 1'b1, 10'h3F8, 1'b1},
    '{8'h25, 8'h00, 1'b0, 10'h3BC, 1'b1, 1'b0, 10'h2F8, 1'b0, 10'h3E8, 1'b1},
    '{8'h7A, 8'h00, 1'b0, 10'h278, 1'b0, 1'b0, 10'h338, 1'b1, 10'h238, 1'b0},
    '{8'hAF, 8'h00, 1'b0, 10'h000, 1'b0, 1'b1, 10'h2E0, 1'b0, 10'h2E8, 1'b1},
    '{8'hF8, 8'h08, 1'b0, 10'h378, 1'b1, 1'b0, 10'h220, 1'b1, 10'h228, 1'b0},
    '{8'h02, 8'h08, 1'b0, 10'h278, 1'b0, 1'b0, 10'h3F8, 1'b1, 10'h3F8, 1'b1},
    '{8'h00, 8'h00, 1'b1, 10'h378, 1'b1, 1'b0, 10'h3F8, 1'b1, 10'h3F8, 1'b1},
    '{8'h02, 8'h00, 1'b1, 10'h278, 1'b1, 1'b0, 10'h3F8, 1'b1, 10'h3F8, 1'b1}};

  assign cfg_base = config_base_strap ? CFG_IDX_ADDR1 : CFG_IDX_ADDR0;

  mio_cfg_top #(.STAB_CYC(STAB)) dut_u (.mclk, .rst_n, .isa_addr, .isa_aen, .isa_ior_n,
    .isa_iow_n, .isa_data_in, .isa_data_out, .isa_data_oe_n, .config_base_strap,
    .port_mode_strap_pin, .config_strap_pins, .xt_mode_pin, .power_down_pin_n,
    .chip_select_out_pin_n, .chip_select_oe_n, .uart1_sout_raw, .uart1_baudout, .uart1_lcr7,
    .uart2_sout_raw, .uart2_baudout, .uart2_lcr7, .fdc_low_power_cmd, .fdc_rate_low_power,
    .serial_out_first, .serial_out_second, .function_enable_reg, .lpt_base, .lpt_irq7_sel,
    .lpt_irq_oe_n, .port_extended_mode, .uart1_base, .uart1_irq4_sel, .uart2_base,
    .uart2_irq4_sel, .uart1_clk_en, .uart2_clk_en, .fdc_clk_en, .xtal_stop, .fdc_rqm_hold);
  mio_host_bfm host_u (.mclk, .isa_addr, .isa_aen, .isa_ior_n, .isa_iow_n, .isa_data_in,
    .isa_data_out);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // Index first, then the data location
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] q;
    host_u.cyc(cfg_base, idx, 1'b0, q);
    host_u.cyc(cfg_base + 10'h1, v, 1'b0, q);
  endtask
  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    host_u.cyc(cfg_base, idx, 1'b0, q);
    host_u.cyc(cfg_base + 10'h1, 8'h00, 1'b1, q);
    chk(q, exp);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask
  task automatic conclude();
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  // Main sequence
  initial
  begin
    {rst_n, config_base_strap, port_mode_strap_pin, xt_mode_pin} = 4'h0;
    {uart1_sout_raw, uart1_baudout, uart1_lcr7, uart2_sout_raw, uart2_baudout} = 5'h0;
    {uart2_lcr7, fdc_low_power_cmd, fdc_rate_low_power} = 3'h0;
    power_down_pin_n  = 1'b1;
    config_strap_pins = 5'h10;
    @(posedge mclk);
    do_reset();
    chk({function_enable_reg, port_extended_mode, xtal_stop, chip_select_oe_n}, 11'h07D);
    cfg_rd(IDX_PTR, 8'h80);
    cfg_rd(IDX_FAR, FAR_RST);
    cfg_rd(8'h03, UNMAPPED_RD);
    foreach (rows[i])
    begin
      @(posedge mclk);
      xt_mode_pin <= rows[i].xt;
      cfg_wr(IDX_FAR, rows[i].function_address_select);
      cfg_wr(IDX_PTR, rows[i].ptr);
      cfg_rd(IDX_FAR, rows[i].function_address_select);
      chk({lpt_irq_oe_n, port_extended_mode}, {rows[i].loe, 1'b0});
      if (!rows[i].loe)
      begin
        chk({lpt_base, lpt_irq7_sel}, {rows[i].lb, rows[i].l7});
      end
      chk({uart1_base, uart1_irq4_sel}, {rows[i].b1, rows[i].i1});
      chk({uart2_base, uart2_irq4_sel}, {rows[i].b2, rows[i].i2});
    end
    // Software power-down with clocks-only stop, then resume
    cfg_wr(IDX_PTR, 8'h01);
    chk({uart1_clk_en, uart2_clk_en, fdc_clk_en, xtal_stop}, 4'h0);
    cfg_wr(IDX_PTR, 8'h00);
    chk({uart1_clk_en, uart2_clk_en, fdc_clk_en, fdc_rqm_hold}, 4'hE);
    cfg_rd(IDX_FAR, 8'h02);
    // Pin power-down, pin as chip select, then crystal stop and settling
    @(posedge mclk);
    power_down_pin_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({uart1_clk_en, fdc_clk_en, xtal_stop}, 3'h0);
    cfg_wr(IDX_PTR, 8'h04);
    chk({uart1_clk_en, fdc_clk_en, chip_select_oe_n}, 3'h6);
    // Chip select is low while a filtered strobe hits the pair, probed mid-strobe
    fork
      host_u.cyc(cfg_base, 8'h00, 1'b1, q);
      begin
        repeat (7) @(posedge mclk);
        chk(chip_select_out_pin_n, 1'b0);
      end
    join
    chk(chip_select_out_pin_n, 1'b1);
    cfg_wr(IDX_PTR, 8'h02);
    chk({xtal_stop, uart1_clk_en}, 2'h2);
    @(posedge mclk);
    power_down_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({xtal_stop, fdc_rqm_hold, uart2_clk_en}, 3'h3);
    repeat (STAB + 8) @(posedge mclk);
    chk(fdc_rqm_hold, 1'b0);
    // Floppy low-power requests under both crystal choices
    cfg_wr(IDX_PTR, 8'h00);
    fdc_rate_low_power <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({fdc_clk_en, uart1_clk_en, xtal_stop}, 3'h2);
    cfg_wr(IDX_PTR, 8'h02);
    chk(xtal_stop, 1'b1);
    fdc_rate_low_power <= 1'b0;
    fdc_low_power_cmd  <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(xtal_stop, 1'b1);
    cfg_wr(IDX_PTR, 8'h00);
    chk({fdc_clk_en, uart1_clk_en, xtal_stop}, 3'h2);
    fdc_low_power_cmd <= 1'b0;
    // Software power-down with crystal stop
    cfg_wr(IDX_PTR, 8'h03);
    chk({xtal_stop, uart1_clk_en, fdc_clk_en}, 3'h4);
    cfg_wr(IDX_PTR, 8'h00);
    // Disabled functions keep their clocks off; no UART or FDC enable stops the crystal
    cfg_wr(IDX_FER, 8'h0D);
    chk({function_enable_reg, uart1_clk_en, uart2_clk_en}, 10'h035);
    cfg_wr(IDX_FER, 8'h01);
    chk({xtal_stop, fdc_clk_en}, 2'h2);
    cfg_wr(IDX_FER, 8'h0F);
    // Test mode drives the baud clock only while line-control bit 7 is set
    for (int j = 0; j < 8; j++)
    begin
      cfg_wr(IDX_PTR, j[2] ? 8'h30 : 8'h00);
      {uart1_lcr7, uart2_lcr7} <= {2{j[1]}};
      {uart1_baudout, uart2_baudout} <= {2{j[0]}};
      {uart1_sout_raw, uart2_sout_raw} <= {2{!j[0]}};
      repeat (3) @(posedge mclk);
      chk({serial_out_first, serial_out_second}, {2{(j[2] && j[1]) == j[0]}});
    end
    // Extended mode is writable; lock then blocks data writes until reset
    cfg_wr(IDX_PTR, 8'h80);
    chk(port_extended_mode, 1'b1);
    cfg_wr(IDX_PTR, 8'h40);
    cfg_wr(IDX_FAR, 8'h25);
    cfg_wr(IDX_PTR, 8'h00);
    cfg_rd(IDX_FAR, 8'h02);
    cfg_rd(IDX_PTR, 8'h40);
    // Second reset: other pair location, all straps high
    config_base_strap   <= 1'b1;
    port_mode_strap_pin <= 1'b1;
    config_strap_pins   <= 5'h1F;
    do_reset();
    chk({function_enable_reg, port_extended_mode, xtal_stop}, 10'h001);
    cfg_rd(IDX_PTR, 8'h00);
    cfg_wr(IDX_FER, 8'h0F);
    cfg_rd(IDX_FER, 8'h0F);
    conclude();
  end
endmodule
`default_nettype wire
